// ---- bench/pgdec_core_sva.sv ----
// Port checker for the character decoder.
// Assumes binding onto pgdec_core with one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pgdec_core_sva
   import pgdec_pkg::*;
#(
   parameter logic [31:0] GAP_CYCLES = 32'd20
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic alternate_numeric_set_select,
   input wire logic char_valid,
   input wire pgdec_char_t char_in,
   input wire logic out_valid,
   input wire pgdec_out_t out_char,
   input wire logic frag_expired
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Code write to the input register at its taking edge
   wire logic in_wr = psel && penable && pwrite && !pready && paddr == 12'h008;
   wire logic [3:0] nc = char_in.code[3:0]; // Numeric code
   wire logic ca = char_valid && char_in.alpha; // Alpha code taken
   ////////////////////////////////////////////////////////////////////////////
   a_out_follows_char: assert property (char_valid |=> out_valid)
      else $error("code gave no output");
   a_out_has_cause: assert property (
      out_valid |-> $past(char_valid) || $past(in_wr))
      else $error("output without code");
   a_alpha_code_map: assert property (
      ca |=> out_char.ch == {1'b0, $past(char_in.code)})
      else $error("alpha code mapped wrong");
   a_etx_is_pad: assert property (
      ca && char_in.code == 7'h03 |=> out_char.pad && !out_char.shown)
      else $error("fill code not padding");
   a_control_hidden: assert property (
      ca && (char_in.code < 7'h20 || char_in.code == 7'h7f) |=> !out_char.shown)
      else $error("control took a position");
   a_printable_shown: assert property (
      ca && char_in.code inside {[7'h20:7'h7e]} |=> out_char.shown && !out_char.pad)
      else $error("printable not shown");
   a_num_digit_map: assert property (
      char_valid && !char_in.alpha && nc < 4'ha |=> out_char.ch == 8'h30 + 8'($past(nc)))
      else $error("digit mapped wrong");
   a_num_space_map: assert property (
      char_valid && !char_in.alpha && nc == 4'hc |=> out_char.ch == 8'h20)
      else $error("numeric space wrong");
   a_expired_sticky: assert property (
      frag_expired && !(psel && penable && pwrite && paddr == 12'h004) |=> frag_expired)
      else $error("expired flag dropped");
   c_etx: cover property (ca && char_in.code == 7'h03);
   c_in_write: cover property (in_wr ##1 out_valid);
   c_expired: cover property ($rose(frag_expired));
endmodule : pgdec_core_sva
bind pgdec_core pgdec_core_sva #(.GAP_CYCLES(GAP_CYCLES)) u_pgdec_core_sva (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .alternate_numeric_set_select, .char_valid, .char_in, .out_valid,
   .out_char, .frag_expired);
`default_nettype wire

// ---- bench/pgdec_core_tb_top.sv ----
// Self-checking bench for the character decoder.
// Assumes core, checker and encoder model compiled first.
`timescale 1ns/1ps
`default_nettype none
module pgdec_core_tb_top;
   import pgdec_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic alternate_numeric_set_select = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, out_valid, frag_expired, char_valid, er;
   pgdec_char_t char_in;
   pgdec_out_t out_char;
   logic [19:0] exp_q[$]; // {mask, expected output}
   logic [19:0] e;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   always #50 pclk = ~pclk;
   pgdec_core #(.GAP_CYCLES(32'd20)) u_pgdec_core (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .alternate_numeric_set_select,
      .char_valid, .char_in, .out_valid, .out_char, .frag_expired);
   pgdec_enc_model u_pgdec_enc_model (.pclk, .char_valid, .char_in);
   ////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Verdict and end of run
   task automatic stop_test();
      $display("errors=%0d checks=%0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   // Output monitor in arrival order, plus timeout
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         stop_test();
      end
      if (out_valid === 1'b1)
      begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 20'hfffff;
         chk(32'(out_char & e[19:10]), 32'(e[9:0]));
      end
   end
   // APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      if (n >= 50)
         error_cnt++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Reset with strap, strap moved afterwards
   task automatic do_reset(input logic s);
      @(posedge pclk);
      presetn <= 1'b0;
      alternate_numeric_set_select <= s;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      alternate_numeric_set_select <= ~s;
   endtask : do_reset
   // Wait out outputs, none may be missing
   task automatic drain();
      u_pgdec_enc_model.idle();
      repeat (3) @(posedge pclk);
      chk(32'(exp_q.size()), 32'h0);
   endtask : drain
   ////////////////////////////////////////////////////////////////////////////
   // All 7-bit codes back to back
   task automatic t_alpha();
      for (int c = 0; c < 128; c++)
      begin
         exp_q.push_back({10'h3ff, !(c < 32 || c == 127), c == 3,
                          1'b0, 7'(c)});
         u_pgdec_enc_model.send(1'b1, 7'(c));
      end
      drain();
   endtask : t_alpha
   // All 4-bit codes in the set fixed at reset
   task automatic t_num(input logic alt);
      logic [47:0] hi;
      logic [7:0] ch;
      hi = alt ? 48'h414220434445 : 48'h3f55202d5d5b;
      for (int c = 0; c < 16; c++)
      begin
         ch = (c < 10) ? 8'(8'h30 + c) : hi[8 * (15 - c) +: 8];
         exp_q.push_back({10'h3ff, 2'b10, ch});
         u_pgdec_enc_model.send(1'b0, 7'(c));
      end
      drain();
   endtask : t_num
   // Every rate setting, readback, unmapped address
   task automatic t_regs();
      for (int r = 0; r < 4; r++)
      begin
         apb(1'b1, 12'h000, 32'(r << 3) | 32'h3);
         apb(1'b0, 12'h004, 32'h0);
         chk(32'(rd[3:2]), 32'(r));
      end
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h1b);
      chk(32'(er), 32'h0);
      apb(1'b0, 12'h014, 32'h0);
      chk(32'(er), 32'h1);
   endtask : t_regs
   // Vector acceptance table {ctrl, probe, verdict}
   task automatic t_accept();
      logic [11:0] t[9] = '{12'h407, 12'h405, 12'h20b, 12'h207, 12'h205, 12'ha03, 12'h00a,
                            12'h414, 12'h202};
      for (int i = 0; i < 9; i++)
      begin
         apb(1'b1, 12'h000, 32'(t[i][11:9]));
         apb(1'b1, 12'h004, 32'(t[i][8:1]));
         repeat (2) @(posedge pclk);
         apb(1'b0, 12'h004, 32'h0);
         chk(32'(rd[1]), 32'(t[i][0]));
      end
   endtask : t_accept
   // Gap timer: quiet, expire, clear; code through the input register
   task automatic t_gap();
      exp_q.push_back({10'h3ff, 10'h242});
      apb(1'b1, 12'h008, 32'hc2);
      apb(1'b0, 12'h004, 32'h0);
      chk(32'(rd[0]), 32'h0);
      repeat (25) @(posedge pclk);
      chk(32'(frag_expired), 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      chk(32'(rd[0]), 32'h1);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk(32'(rd[0]), 32'h0);
      chk(32'(frag_expired), 32'h0);
      chk(32'(exp_q.size()), 32'h0);
      // Last decoded character and count since the second reset: 16 + 128 + 1
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h242);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'd145);
   endtask : t_gap
   // Main sequence
   initial
   begin
      do_reset(1'b1);
      apb(1'b0, 12'h004, 32'h0);
      chk(32'(rd[4]), 32'h1);
      t_num(1'b1);
      do_reset(1'b0);
      t_num(1'b0);
      t_alpha();
      t_regs();
      t_accept();
      t_gap();
      stop_test();
   end
endmodule : pgdec_core_tb_top
`default_nettype wire

// ---- bench/pgdec_enc_model.sv ----
// Encoder-side model: streams received codes into the decoder.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
`default_nettype none
module pgdec_enc_model
   import pgdec_pkg::*;
(
   input wire logic pclk,
   output logic char_valid,
   output pgdec_char_t char_in
);
   // Idle line at start
   initial
   begin
      char_valid = 1'b0;
      char_in = '0;
   end
   // Whole characters of unfragmented, unnumbered messages, no addresses
   task automatic send(input logic a, input logic [6:0] c);
      @(posedge pclk);
      char_valid <= 1'b1;
      char_in <= {a, c};
   endtask : send
   // Gap: data line changes so stale codes never look valid
   task automatic idle();
      @(posedge pclk);
      char_valid <= 1'b0;
      char_in <= ~char_in;
   endtask : idle
endmodule : pgdec_enc_model
`default_nettype wire

// ---- core/pgdec_core.sv ----
// APB slave mapping received character codes to display characters.
// Assumes one 10 MHz clock, asynchronous active-low reset, APB master.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pgdec_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - Single-phase or any-phase address matching (no addresses matched; phase mode only gates short instructions)
// - Numeric implies short message type 00
// - Alphanumeric implies numeric and short message
// - Any-phase alphanumeric implies short instruction 000
// - Four rate and modulation combinations
// - Tolerate four minute fragment gaps
// - Seven-bit code, column and row ASCII
// - Unacted controls take no display position
// - Standard numeric set mapping
// - Alternate numeric set mapping
// - End-of-text fills unused positions
module pgdec_core
   import pgdec_pkg::*;
#(
   parameter logic [31:0] GAP_CYCLES = 32'(64'(`PGDEC_GAP_SEC) * `PGDEC_CLK_HZ)
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic alternate_numeric_set_select,
   input wire logic char_valid,
   input wire pgdec_char_t char_in,
   output logic out_valid,
   output pgdec_out_t out_char,
   output logic frag_expired
);

   ////////////////////////////////////////////////////////////////////////////
   // State declarations
   logic [4:0] ctrl_reg;        // Accepted types, phase mode, rate
   logic [4:0] ctrl_next;
   logic alt_reg;               // Strapped numeric set
   logic alt_next;
   logic strap_done_reg;        // Strap already caught
   logic strap_done_next;
   logic out_valid_reg;
   logic out_valid_next;
   pgdec_out_t out_reg;
   pgdec_out_t out_next;
   logic [15:0] count_reg;      // Characters produced
   logic [15:0] count_next;
   logic [31:0] gap_reg;        // Cycles since last fragment
   logic [31:0] gap_next;
   logic expired_reg;           // Gap ran out, sticky
   logic expired_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [2:0] vt_reg;          // Last vector type probed
   logic [2:0] vt_next;
   logic [2:0] it_reg;          // Last instruction type probed
   logic [2:0] it_next;
   logic [1:0] mt_reg;          // Last message type probed
   logic [1:0] mt_next;
   logic accept_reg;            // Probe verdict
   logic accept_next;

   // Derived control views
   logic cfg_alpha;
   logic cfg_num;
   logic cfg_anyph;
   pgdec_rate_t cfg_rate;
   logic acc_phase;             // APB access taken this edge
   logic sw_char;               // Character written by software
   pgdec_char_t src_char;       // Character to decode now
   logic src_valid;

   assign acc_phase = psel & penable & ~pready_reg;
   assign cfg_alpha = ctrl_reg[`PGDEC_C_ALPHA];
   assign cfg_num = ctrl_reg[`PGDEC_C_NUM] | cfg_alpha;
   assign cfg_anyph = ctrl_reg[`PGDEC_C_ANYPH];
   assign cfg_rate = pgdec_rate_t'(ctrl_reg[`PGDEC_C_RATE_HI:`PGDEC_C_RATE_LO]);
   assign sw_char = acc_phase & pwrite & (paddr == `PGDEC_IN_OFF);
   // Pin stream has priority; software path used when pins idle
   assign src_valid = char_valid | sw_char;
   assign src_char = char_valid ? char_in : pgdec_char_t'(pwdata[7:0]);

   ////////////////////////////////////////////////////////////////////////////
   // Numeric code to display character
   function automatic logic [7:0] pgdec_num_map(input logic [3:0] c, input logic alt);
      logic [7:0] r;
      r = `PGDEC_SPARE;
      if (c < `PGDEC_TEN)
         r = `PGDEC_DIG0 + {4'h0, c};
      else if (alt)
      begin
         unique case (c)
            4'ha: r = 8'h41;
            4'hb: r = 8'h42;
            4'hc: r = `PGDEC_SPC;
            4'hd: r = 8'h43;
            4'he: r = 8'h44;
            default: r = 8'h45;
         endcase
      end
      else
      begin
         unique case (c)
            4'ha: r = `PGDEC_SPARE;
            4'hb: r = 8'h55;
            4'hc: r = `PGDEC_SPC;
            4'hd: r = 8'h2d;
            4'he: r = 8'h5d;
            default: r = 8'h5b;
         endcase
      end
      return r;
   endfunction : pgdec_num_map

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture after reset release
   always_comb
   begin
      alt_next = alt_reg;
      strap_done_next = 1'b1;
      if (!strap_done_reg)
         alt_next = alternate_numeric_set_select;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alt_reg <= 1'b0;
         strap_done_reg <= 1'b0;
      end
      else
      begin
         alt_reg <= alt_next;
         strap_done_reg <= strap_done_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Character decode, one result per cycle
   always_comb
   begin
      out_valid_next = src_valid;
      out_next = out_reg;
      count_next = count_reg;
      if (src_valid)
      begin
         count_next = count_reg + 16'h0001;
         if (src_char.alpha)
         begin
            // Seven bits straight to ASCII column and row
            out_next.ch = {1'b0, src_char.code};
            out_next.pad = (src_char.code == `PGDEC_ETX);
            // Controls and delete keep no display slot but still emit
            out_next.shown = (src_char.code > `PGDEC_CTRL_TOP) &&
                             (src_char.code != `PGDEC_DEL);
         end
         else
         begin
            out_next.ch = pgdec_num_map(src_char.code[3:0], alt_reg);
            out_next.pad = 1'b0;
            out_next.shown = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_valid_reg <= 1'b0;
         out_reg <= '0;
         count_reg <= 16'h0000;
      end
      else
      begin
         out_valid_reg <= out_valid_next;
         out_reg <= out_next;
         count_reg <= count_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fragment gap timer; any character restarts it
   always_comb
   begin
      gap_next = gap_reg;
      expired_next = expired_reg;
      if (src_valid)
         gap_next = 32'h0000_0000;
      else if (gap_reg != GAP_CYCLES)
         gap_next = gap_reg + 32'h0000_0001;
      // Set wins over a software clear in the same cycle
      if (acc_phase && pwrite && paddr == `PGDEC_STAT_OFF)
         expired_next = 1'b0;
      if (!src_valid && gap_reg == GAP_CYCLES - 32'h0000_0001)
         expired_next = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_reg <= 32'h0000_0000;
         expired_reg <= 1'b0;
      end
      else
      begin
         gap_reg <= gap_next;
         expired_reg <= expired_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Vector acceptance verdict for a probed header
   function automatic logic pgdec_accept(input logic [2:0] vt, input logic [1:0] mt,
                                         input logic [2:0] it);
      logic a;
      a = 1'b0;
      unique case (vt)
         `PGDEC_VT_ALPHA: a = cfg_alpha;
         `PGDEC_VT_NUM, `PGDEC_VT_NUMSP, `PGDEC_VT_NUMNS: a = cfg_num;
         `PGDEC_VT_SHORT: a = cfg_num && (mt == `PGDEC_MT_ZERO);
         `PGDEC_VT_SINSTR: a = cfg_alpha && cfg_anyph && (it == `PGDEC_IT_ZERO);
         default: a = 1'b0;
      endcase
      return a;
   endfunction : pgdec_accept

   ////////////////////////////////////////////////////////////////////////////
   // APB register access, answered one cycle after the access phase starts
   always_comb
   begin
      ctrl_next = ctrl_reg;
      vt_next = vt_reg;
      mt_next = mt_reg;
      it_next = it_reg;
      prdata_next = prdata_reg;
      pready_next = acc_phase;
      pslverr_next = 1'b0;
      if (acc_phase)
      begin
         unique case (paddr)
            `PGDEC_CTRL_OFF:
            begin
               if (pwrite)
                  ctrl_next = pwdata[4:0];
               prdata_next = {27'h0, ctrl_reg};
            end
            `PGDEC_STAT_OFF:
            begin
               // Write 8 bits: vt, mt, it probe fields; read verdict/status
               if (pwrite)
               begin
                  vt_next = pwdata[2:0];
                  mt_next = pwdata[4:3];
                  it_next = pwdata[7:5];
               end
               prdata_next = {27'h0, alt_reg, cfg_rate, accept_reg, expired_reg};
            end
            `PGDEC_IN_OFF: prdata_next = 32'h0000_0000;
            `PGDEC_OUT_OFF: prdata_next = {22'h0, out_reg};
            `PGDEC_CNT_OFF: prdata_next = {16'h0, count_reg};
            default:
            begin
               prdata_next = 32'h0000_0000;
               pslverr_next = 1'b1;
            end
         endcase
      end
      accept_next = pgdec_accept(vt_reg, mt_reg, it_reg);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= 5'h00;
         vt_reg <= 3'h0;
         mt_reg <= 2'h0;
         it_reg <= 3'h0;
         accept_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         vt_reg <= vt_next;
         mt_reg <= mt_next;
         it_reg <= it_next;
         accept_reg <= accept_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Outputs straight from flip-flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign out_valid = out_valid_reg;
   assign out_char = out_reg;
   assign frag_expired = expired_reg;

endmodule : pgdec_core
`default_nettype wire

// ---- core/pgdec_defines.svh ----
// Constants for the paging message character decoder.
// Assumes inclusion by bare name from core files.
`ifndef PGDEC_DEFINES_SVH
`define PGDEC_DEFINES_SVH
// Register byte offsets
`define PGDEC_CTRL_OFF 12'h000
`define PGDEC_STAT_OFF 12'h004
`define PGDEC_IN_OFF 12'h008
`define PGDEC_OUT_OFF 12'h00c
`define PGDEC_CNT_OFF 12'h010
// Vector type codes
`define PGDEC_VT_SINSTR 3'h1
`define PGDEC_VT_SHORT 3'h2
`define PGDEC_VT_NUM 3'h3
`define PGDEC_VT_NUMSP 3'h4
`define PGDEC_VT_ALPHA 3'h5
`define PGDEC_VT_NUMNS 3'h7
`define PGDEC_MT_ZERO 2'h0
`define PGDEC_IT_ZERO 3'h0
// Character constants
`define PGDEC_ETX 7'h03
`define PGDEC_SPC 8'h20
`define PGDEC_DIG0 8'h30
`define PGDEC_SPARE 8'h3f
`define PGDEC_CTRL_TOP 7'h1f
`define PGDEC_DEL 7'h7f
`define PGDEC_TEN 4'ha
// Control field positions
`define PGDEC_C_ALPHA 0
`define PGDEC_C_NUM 1
`define PGDEC_C_ANYPH 2
`define PGDEC_C_RATE_LO 3
`define PGDEC_C_RATE_HI 4
// Fragment gap limit: 4 minutes at 100 ns = 2.4e9 cycles
`define PGDEC_GAP_SEC 240
`define PGDEC_CLK_HZ 10000000
`endif

// ---- core/pgdec_pkg.sv ----
// Types for the paging message character decoder.
// Assumes the defines header sits beside it.
package pgdec_pkg;
   // One input character record
   typedef struct packed {
      logic alpha;      // 1: 7-bit code, 0: 4-bit code
      logic [6:0] code; // Received code
   } pgdec_char_t;
   // One output character record
   typedef struct packed {
      logic shown;      // Takes a display position
      logic pad;        // Fill code, not content
      logic [7:0] ch;   // Mapped character
   } pgdec_out_t;
   // Supported rate and modulation combinations
   typedef enum logic [1:0] {
      PGDEC_R1600_2 = 2'b00,
      PGDEC_R3200_2 = 2'b01,
      PGDEC_R3200_4 = 2'b10,
      PGDEC_R6400_4 = 2'b11
   } pgdec_rate_t;
endpackage : pgdec_pkg
